// ===== design/debug_port_pkg.sv
// Constants and types shared by the background debug command engine.
// Notes on behaviour
// - Serial bit clock is the VCO clock divided by eight.
// - Each command is an 8-bit opcode, then address and/or data words of 16 bits.
// - Every read command returns exactly sixteen bits.
// - Byte read: even address data in upper byte, odd address in lower.
// - Opcode 62 adds two to X, then reads word at new X.
// - Opcodes 63..67 read_program_counter_cmd, D, X, Y and stack pointer.
// - Opcode 42 adds two to X, then writes word at new X.
// - Opcodes 43..47 load PC, D, X, Y and stack pointer.
// - Opcode 08 resumes the user program; acknowledge on leaving background.
// - Opcode 0C runs the user program; acknowledge when background is re-entered.
// - Opcode 10 runs one instruction, returns, acknowledges on return.
// - Obsolete opcode 18 behaves exactly like resume.
// - Reads acknowledge when data is ready; writes when the write completes.
// - Auto-increment into debug space hits debug resources; firmware not writable.
// - System stop disables acknowledge; ignored commands get no pulse.
// - Run-until is not acknowledged if wait or stop comes first.
// - Acknowledge drives the pin low sixteen serial clocks, then a speed-up pulse.
// - Pulse starts no sooner than 32 serial clocks after command end.
// - Wait or stop before execution drops the pending command, unacknowledged.
package debug_port_pkg;
  localparam logic [7:0] OP_READ_NEXT = 8'h62;
  localparam logic [7:0] OP_READ_PROGRAM_COUNTER_CMD = 8'h63;
  localparam logic [7:0] OP_READ_D = 8'h64;
  localparam logic [7:0] OP_READ_X = 8'h65;
  localparam logic [7:0] OP_READ_Y = 8'h66;
  localparam logic [7:0] OP_READ_STACK_POINTER_CMD = 8'h67;
  localparam logic [7:0] OP_WRITE_NEXT = 8'h42;
  localparam logic [7:0] OP_WRITE_PROGRAM_COUNTER_CMD = 8'h43;
  localparam logic [7:0] OP_WRITE_D = 8'h44;
  localparam logic [7:0] OP_WRITE_X = 8'h45;
  localparam logic [7:0] OP_WRITE_Y = 8'h46;
  localparam logic [7:0] OP_WRITE_STACK_POINTER_CMD = 8'h47;
  localparam logic [7:0] OP_RESUME = 8'h08;
  localparam logic [7:0] OP_RUN_UNTIL = 8'h0c;
  localparam logic [7:0] OP_SINGLE_STEP = 8'h10;
  localparam logic [7:0] OP_TAG_RESUME = 8'h18;
  // Serial clock divide ratio from the VCO clock
  localparam int SERIAL_DIV = 8;
  localparam logic [2:0] SERIAL_DIV_LAST = 3'h7;
  // Acknowledge low time and least delay, in serial clocks
  localparam logic [5:0] ACK_LOW_TICKS = 6'h10;
  localparam logic [5:0] ACK_MIN_DELAY_TICKS = 6'h20;
  // Speed-up pulse length in system clocks
  localparam logic [2:0] SPEEDUP_CYCLES = 3'h2;
  localparam logic [15:0] X_STEP = 16'h0002;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Debug resource window in the address map
  localparam logic [15:0] DEBUG_SPACE_BASE = 16'hff00;
  localparam logic [15:0] DEBUG_SPACE_MASK = 16'hff00;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_BUS = 6'b000010,
    ST_USER = 6'b000100,
    ST_WAIT_MIN = 6'b001000,
    ST_ACK_LOW = 6'b010000,
    ST_SPEEDUP = 6'b100000
  } engine_state_t;
endpackage

// ===== design/serial_tick_gen.sv
// Debug serial clock tick generator: VCO clock divided by eight.
`default_nettype none
module serial_tick_gen
  import debug_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic vco_clk_en,
  output logic serial_tick
);
  logic [2:0] div_count;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_count <= 3'h0;
      serial_tick <= 1'b0;
    end else begin
      serial_tick <= 1'b0;
      if (vco_clk_en) begin
        div_count <= div_count + 3'h1;
        serial_tick <= (div_count == SERIAL_DIV_LAST);
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/background_debug_port.sv
// Firmware command engine of the single-wire background debug port.
`default_nettype none
module background_debug_port
  import debug_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic vco_clk_en,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [15:0] cmd_data,
  input wire logic cmd_byte,
  input wire logic [15:0] cmd_addr,
  input wire logic ack_enable_set,
  input wire logic ack_enable_clear,
  input wire logic system_stop,
  input wire logic cpu_wait_stop,
  input wire logic bus_done,
  input wire logic [15:0] bus_rdata,
  input wire logic user_step_done,
  input wire logic background_entered,
  output logic cmd_ready,
  output logic bus_req,
  output logic bus_write,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic debug_space_sel,
  output logic user_run,
  output logic user_single_step,
  output logic [15:0] read_data,
  output logic read_data_valid,
  output logic ack_enable,
  output logic debug_serial_pin_out,
  output logic debug_serial_pin_oe
);
  engine_state_t state;
  logic serial_tick;
  logic [15:0] reg_pc, reg_d, reg_x, reg_y, reg_sp;
  logic [5:0] tick_count;
  logic [2:0] speed_count;
  logic is_read_next, is_write_next, is_read_reg, is_write_reg, is_go, is_until, is_step;
  logic in_debug_space, want_ack, bus_is_write, byte_access;
  logic [15:0] next_x;

  // ------------------------------------------------------------
  // Serial clock
  // ------------------------------------------------------------
  serial_tick_gen u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .vco_clk_en(vco_clk_en),
    .serial_tick(serial_tick)
  );

  // ------------------------------------------------------------
  // Opcode decode
  // ------------------------------------------------------------
  // opcode classes
  assign is_read_next = (cmd_opcode == OP_READ_NEXT);
  assign is_write_next = (cmd_opcode == OP_WRITE_NEXT);
  assign is_read_reg = (cmd_opcode >= OP_READ_PROGRAM_COUNTER_CMD) && (cmd_opcode <= OP_READ_STACK_POINTER_CMD);
  assign is_write_reg = (cmd_opcode >= OP_WRITE_PROGRAM_COUNTER_CMD) && (cmd_opcode <= OP_WRITE_STACK_POINTER_CMD);
  assign is_go = (cmd_opcode == OP_RESUME) || (cmd_opcode == OP_TAG_RESUME);
  assign is_until = (cmd_opcode == OP_RUN_UNTIL);
  assign is_step = (cmd_opcode == OP_SINGLE_STEP);
  assign next_x = reg_x + X_STEP;
  assign in_debug_space = ((next_x & DEBUG_SPACE_MASK) == DEBUG_SPACE_BASE);
  assign want_ack = ack_enable && !system_stop;

  // ------------------------------------------------------------
  // Acknowledge enable
  // ------------------------------------------------------------
  // cleared at reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_enable <= 1'b0;
    end else if (ack_enable_set) begin
      ack_enable <= 1'b1;
    end else if (ack_enable_clear) begin
      ack_enable <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  // Commands are only taken in idle; a stop drops any pending one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      tick_count <= 6'h0;
      speed_count <= 3'h0;
      bus_req <= 1'b0;
      bus_write <= 1'b0;
      bus_is_write <= 1'b0;
      byte_access <= 1'b0;
      bus_addr <= RESET_WORD;
      bus_wdata <= RESET_WORD;
      debug_space_sel <= 1'b0;
      user_run <= 1'b0;
      user_single_step <= 1'b0;
      read_data <= RESET_WORD;
      read_data_valid <= 1'b0;
      debug_serial_pin_out <= 1'b1;
      debug_serial_pin_oe <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      read_data_valid <= 1'b0;
      user_single_step <= 1'b0;
      cmd_ready <= (state == ST_IDLE) && !cmd_valid;
      // Back in background: the program no longer runs
      if (background_entered || user_step_done) begin
        user_run <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (cmd_valid && !system_stop) begin
            tick_count <= 6'h0;
            cmd_ready <= 1'b0;
            if (is_read_next || is_write_next) begin
              bus_req <= 1'b1;
              bus_write <= is_write_next && !in_debug_space;
              bus_is_write <= is_write_next;
              bus_addr <= next_x;
              bus_wdata <= cmd_data;
              // Latched: the host may change the byte flag once taken
              byte_access <= cmd_byte;
              debug_space_sel <= in_debug_space;
              state <= ST_BUS;
            end else if (is_read_reg) begin
              case (cmd_opcode)
                OP_READ_PROGRAM_COUNTER_CMD: read_data <= reg_pc;
                OP_READ_D: read_data <= reg_d;
                OP_READ_X: read_data <= reg_x;
                OP_READ_Y: read_data <= reg_y;
                default: read_data <= reg_sp;
              endcase
              read_data_valid <= 1'b1;
              state <= want_ack ? ST_WAIT_MIN : ST_IDLE;
            end else if (is_write_reg) begin
              state <= want_ack ? ST_WAIT_MIN : ST_IDLE;
            end else if (is_go) begin
              user_run <= 1'b1;
              state <= want_ack ? ST_WAIT_MIN : ST_IDLE;
            end else if (is_until || is_step) begin
              user_run <= 1'b1;
              user_single_step <= is_step;
              state <= ST_USER;
            end
          end
        end
        ST_BUS: begin
          // wait or stop drops the command
          if (cpu_wait_stop || system_stop) begin
            bus_req <= 1'b0;
            bus_write <= 1'b0;
            state <= ST_IDLE;
          end else if (bus_done) begin
            bus_req <= 1'b0;
            bus_write <= 1'b0;
            if (!bus_is_write) begin
              if (byte_access) begin
                read_data <= bus_addr[0] ? {8'h00, bus_rdata[7:0]}
                                         : {bus_rdata[15:8], 8'h00};
              end else begin
                read_data <= bus_rdata;
              end
              read_data_valid <= 1'b1;
            end
            // ack once data ready or write done
            state <= want_ack ? ST_WAIT_MIN : ST_IDLE;
          end
        end
        ST_USER: begin
          // wait or stop cancels the ack
          if (cpu_wait_stop || system_stop) begin
            state <= ST_IDLE;
          end else if (background_entered || user_step_done) begin
            user_run <= 1'b0;
            state <= want_ack ? ST_WAIT_MIN : ST_IDLE;
          end
        end
        ST_WAIT_MIN: begin
          if (system_stop) begin
            state <= ST_IDLE;
          end else if (serial_tick) begin
            if (tick_count == ACK_MIN_DELAY_TICKS - 6'h1) begin
              tick_count <= 6'h0;
              debug_serial_pin_out <= 1'b0;
              debug_serial_pin_oe <= 1'b1;
              state <= ST_ACK_LOW;
            end else begin
              tick_count <= tick_count + 6'h1;
            end
          end
        end
        ST_ACK_LOW: begin
          if (serial_tick) begin
            if (tick_count == ACK_LOW_TICKS - 6'h1) begin
              debug_serial_pin_out <= 1'b1;
              speed_count <= 3'h0;
              state <= ST_SPEEDUP;
            end else begin
              tick_count <= tick_count + 6'h1;
            end
          end
        end
        ST_SPEEDUP: begin
          if (speed_count == SPEEDUP_CYCLES - 3'h1) begin
            debug_serial_pin_oe <= 1'b0;
            state <= ST_IDLE;
          end else begin
            speed_count <= speed_count + 3'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // CPU register file
  // ------------------------------------------------------------
  // register loads; X steps by two
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_pc <= RESET_WORD;
      reg_d <= RESET_WORD;
      reg_x <= RESET_WORD;
      reg_y <= RESET_WORD;
      reg_sp <= RESET_WORD;
    end else if (state == ST_IDLE && cmd_valid && !system_stop) begin
      if (is_read_next || is_write_next) begin
        reg_x <= next_x;
      end else begin
        case (cmd_opcode)
          OP_WRITE_PROGRAM_COUNTER_CMD: reg_pc <= cmd_data;
          OP_WRITE_D: reg_d <= cmd_data;
          OP_WRITE_X: reg_x <= cmd_data;
          OP_WRITE_Y: reg_y <= cmd_data;
          OP_WRITE_STACK_POINTER_CMD: reg_sp <= cmd_data;
          default: reg_pc <= reg_pc;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Serial ticks seen in the low phase; bound holds at any VCO rate
  logic [7:0] low_ticks;
  always_ff @(posedge clk_sys) begin
    if (reset || state != ST_ACK_LOW) begin
      low_ticks <= 8'h0;
    end else if (serial_tick) begin
      low_ticks <= low_ticks + 8'h1;
    end
  end

  property p_ack_low_len;
    @(posedge clk_sys) disable iff (reset)
      (state == ST_ACK_LOW) |-> (low_ticks < {2'h0, ACK_LOW_TICKS}) && debug_serial_pin_oe
        && !debug_serial_pin_out;
  endproperty
  a_ack_low_len: assert property (p_ack_low_len) else $error("ack low too long");

  property p_no_ack_disabled;
    @(posedge clk_sys) disable iff (reset)
      (!ack_enable && state == ST_IDLE) |=> (state != ST_WAIT_MIN);
  endproperty
  a_no_ack_disabled: assert property (p_no_ack_disabled) else $error("ack while off");

  property p_stop_no_ack;
    @(posedge clk_sys) disable iff (reset)
      (system_stop && state == ST_WAIT_MIN) |=> (state == ST_IDLE);
  endproperty
  a_stop_no_ack: assert property (p_stop_no_ack) else $error("ack in stop");

  property p_min_delay;
    @(posedge clk_sys) disable iff (reset)
      $rose(state == ST_ACK_LOW) |-> $past(tick_count) == ACK_MIN_DELAY_TICKS - 6'h1;
  endproperty
  a_min_delay: assert property (p_min_delay) else $error("ack too early");

  property p_x_step;
    @(posedge clk_sys) disable iff (reset)
      (state == ST_IDLE && cmd_valid && !system_stop && is_read_next)
        |=> (reg_x == $past(reg_x) + X_STEP) && (bus_addr == reg_x);
  endproperty
  a_x_step: assert property (p_x_step) else $error("x not stepped");

  property p_no_fw_write;
    @(posedge clk_sys) disable iff (reset)
      debug_space_sel |-> !bus_write;
  endproperty
  a_no_fw_write: assert property (p_no_fw_write) else $error("firmware write");

  property p_drop_on_wait;
    @(posedge clk_sys) disable iff (reset)
      (state == ST_BUS && cpu_wait_stop) |=> (state == ST_IDLE) && !bus_req;
  endproperty
  a_drop_on_wait: assert property (p_drop_on_wait) else $error("not dropped");

  property p_until_wait;
    @(posedge clk_sys) disable iff (reset)
      (state == ST_USER && cpu_wait_stop) |=> (state == ST_IDLE);
  endproperty
  a_until_wait: assert property (p_until_wait) else $error("until acked after wait");

  property p_byte_odd;
    @(posedge clk_sys) disable iff (reset)
      (state == ST_BUS && bus_done && !cpu_wait_stop && !system_stop && !bus_is_write
       && byte_access && bus_addr[0]) |=> read_data[15:8] == 8'h00;
  endproperty
  a_byte_odd: assert property (p_byte_odd) else $error("odd byte lane");

  sequence s_low_last;
    (state == ST_ACK_LOW) && serial_tick && (tick_count == ACK_LOW_TICKS - 6'h1);
  endsequence
  sequence s_speedup_release;
    (debug_serial_pin_oe && debug_serial_pin_out) [*2] ##1 !debug_serial_pin_oe;
  endsequence
  property p_speedup;
    @(posedge clk_sys) disable iff (reset)
      s_low_last |=> s_speedup_release;
  endproperty
  a_speedup: assert property (p_speedup) else $error("speed-up pulse wrong");

  property p_reg_read;
    @(posedge clk_sys) disable iff (reset)
      (state == ST_IDLE && cmd_valid && !system_stop && cmd_opcode == OP_READ_X)
        |=> read_data_valid && (read_data == $past(reg_x));
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("register read wrong");
endmodule
`default_nettype wire

// ===== tb/cpu_side_model.sv
// Behavioural CPU side: bus responder and user-program returns.
`default_nettype none
module cpu_side_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic bus_req,
  input wire logic [15:0] bus_addr,
  input wire logic user_run,
  input wire logic user_single_step,
  input wire logic return_en,
  output logic bus_done,
  output logic [15:0] bus_rdata,
  output logic user_step_done,
  output logic background_entered
);
  timeunit 1ns;
  timeprecision 1ns;
  int bus_wait;
  int run_wait;
  logic step_pend;
  // Bus answers 2 to 8 cycles after the request; data moves outside the done cycle
  always_ff @(posedge clk_sys) begin
    bus_done <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (reset) begin
      bus_wait <= 0;
      bus_rdata <= 16'h0000;
    end else if (bus_req && !bus_done) begin
      if (bus_wait == 0) begin
        bus_wait <= 1 + $urandom_range(6);
      end else if (bus_wait == 1) begin
        bus_done <= 1'b1;
        bus_rdata <= bus_addr ^ 16'h5a3c;
        bus_wait <= 0;
      end else begin
        bus_wait <= bus_wait - 1;
      end
    end else if (!bus_req) begin
      // A dropped request leaves no stale wait behind
      bus_wait <= 0;
    end
  end
  // Steps always return; a run returns only while the bench allows it
  always_ff @(posedge clk_sys) begin
    user_step_done <= 1'b0;
    background_entered <= 1'b0;
    if (reset) begin
      run_wait <= 0;
      step_pend <= 1'b0;
    end else if (user_single_step) begin
      run_wait <= 2 + $urandom_range(20);
      step_pend <= 1'b1;
    end else if (run_wait == 0 && user_run && return_en && !user_step_done
                 && !background_entered) begin
      run_wait <= 2 + $urandom_range(20);
      step_pend <= 1'b0;
    end else if (run_wait == 1) begin
      run_wait <= 0;
      user_step_done <= step_pend;
      background_entered <= !step_pend;
    end else if (run_wait > 1) begin
      run_wait <= run_wait - 1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_background_debug_port.sv
// Self-checking bench for the background debug command engine.
`default_nettype none
module test_background_debug_port;
  import debug_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset, vco_clk_en, vco_half, cmd_valid, cmd_byte, return_en;
  logic ack_enable_set, ack_enable_clear, system_stop, cpu_wait_stop, bus_done;
  logic user_step_done, background_entered, cmd_ready, bus_req, bus_write, ack_enable;
  logic debug_space_sel, user_run, user_single_step, read_data_valid, oe_q, req_q;
  logic debug_serial_pin_out, debug_serial_pin_oe, cap_write, cap_sel;
  logic [7:0] cmd_opcode;
  logic [15:0] cmd_data, cmd_addr, bus_rdata, bus_addr, bus_wdata, read_data;
  logic [15:0] rd_cap, cap_addr, cap_wdata, x, v;
  logic [7:0] ack_ops [6];
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rdv_cyc = 0;
  int ack_cyc = 0;
  int ret_cyc = 0;
  int ack_count = 0;
  int low_len = 0;
  int a0;
  int r0;

  background_debug_port i_background_debug_port (.clk_sys(clk_sys), .reset(reset),
    .vco_clk_en(vco_clk_en), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_data(cmd_data), .cmd_byte(cmd_byte), .cmd_addr(cmd_addr),
    .ack_enable_set(ack_enable_set), .ack_enable_clear(ack_enable_clear),
    .system_stop(system_stop), .cpu_wait_stop(cpu_wait_stop), .bus_done(bus_done),
    .bus_rdata(bus_rdata), .user_step_done(user_step_done),
    .background_entered(background_entered), .cmd_ready(cmd_ready), .bus_req(bus_req),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .debug_space_sel(debug_space_sel), .user_run(user_run),
    .user_single_step(user_single_step), .read_data(read_data),
    .read_data_valid(read_data_valid), .ack_enable(ack_enable),
    .debug_serial_pin_out(debug_serial_pin_out), .debug_serial_pin_oe(debug_serial_pin_oe));

  cpu_side_model i_cpu_side_model (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
    .bus_addr(bus_addr), .user_run(user_run), .user_single_step(user_single_step),
    .return_en(return_en), .bus_done(bus_done), .bus_rdata(bus_rdata),
    .user_step_done(user_step_done), .background_entered(background_entered));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // VCO enable every cycle, or every other cycle to slow the serial clock
  always @(posedge clk_sys) vco_clk_en <= vco_half ? ~vco_clk_en : 1'b1;

  // Timestamps and captures; acknowledge low time counted in clocks
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    oe_q <= debug_serial_pin_oe;
    req_q <= bus_req;
    if (read_data_valid) begin
      rdv_cyc <= cyc;
      rd_cap <= read_data;
    end
    if (user_step_done || background_entered) ret_cyc <= cyc;
    if (bus_req && !req_q) begin
      cap_addr <= bus_addr;
      cap_wdata <= bus_wdata;
      cap_write <= bus_write;
      cap_sel <= debug_space_sel;
    end
    if (debug_serial_pin_oe && !oe_q) begin
      ack_count <= ack_count + 1;
      ack_cyc <= cyc;
      low_len <= 1;
    end else if (debug_serial_pin_oe && !debug_serial_pin_out) begin
      low_len <= low_len + 1;
    end
  end

  // Returned word as seen on the bus lanes
  // byte lane placement
  function automatic logic [15:0] exp_read(input logic [15:0] a, input logic b);
    logic [15:0] w;
    w = a ^ 16'h5a3c;
    if (!b) return w;
    return a[0] ? {8'h00, w[7:0]} : {w[15:8], 8'h00};
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Slow targets may take long; the bound only catches a hang
  // generous wait
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20000) chk("idle wait", 1, 0);
  endtask

  // Opcode plus one data word, held for one cycle only
  // command shape
  task automatic issue(input logic [7:0] op, input logic [15:0] d, input logic b);
    wait_idle();
    cmd_opcode <= op;
    cmd_data <= d;
    cmd_byte <= b;
    cmd_addr <= 16'($urandom);
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask

  // Next command only once the previous one, with its pulse, is over
  // host waits
  task automatic run_cmd(input logic [7:0] op, input logic [15:0] d, input logic b);
    issue(op, d, b);
    wait_idle();
  endtask

  task automatic pulse_en(input logic s, input logic c);
    ack_enable_set <= s;
    ack_enable_clear <= c;
    @(posedge clk_sys);
    ack_enable_set <= 1'b0;
    ack_enable_clear <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    complete_run();
  end

  // Main sequence
  initial begin
    a0 = $urandom(5071);
    ack_ops = '{OP_READ_X, OP_WRITE_D, OP_RESUME, OP_TAG_RESUME, OP_RUN_UNTIL, OP_SINGLE_STEP};
    {reset, vco_half, cmd_valid, cmd_byte, ack_enable_set, ack_enable_clear} <= 6'h21;
    {system_stop, cpu_wait_stop} <= 2'h0;
    return_en <= 1'b1;
    cmd_opcode <= 8'h00;
    cmd_data <= 16'h0000;
    cmd_addr <= 16'h0000;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    chk("pin idle", 3'h4, {debug_serial_pin_out, debug_serial_pin_oe, ack_enable});
    for (int i = 0; i < 5; i++) begin
      v = 16'($urandom);
      run_cmd(OP_WRITE_PROGRAM_COUNTER_CMD + 8'(i), v, 1'b0);
      run_cmd(OP_READ_PROGRAM_COUNTER_CMD + 8'(i), 16'h0000, 1'b0);
      chk("register readback", 32'(v), 32'(rd_cap));
    end
    x = 16'($urandom_range(16'hfe00));
    v = 16'($urandom);
    run_cmd(OP_WRITE_X, x, 1'b0);
    run_cmd(OP_WRITE_NEXT, v, 1'b0);
    chk("next write", {x + X_STEP, v}, {cap_addr, cap_wdata});
    chk("next write strobe", 2, {cap_write, cap_sel});
    run_cmd(OP_READ_NEXT, 16'h0000, 1'b0);
    chk("next read", {x + 16'h0004, exp_read(x + 16'h0004, 1'b0)}, {cap_addr, rd_cap});
    for (int b = 0; b < 2; b++) begin
      x = {15'($urandom_range(16'h7e00)), 1'(b)};
      run_cmd(OP_WRITE_X, x, 1'b0);
      run_cmd(OP_READ_NEXT, 16'h0000, 1'b1);
      chk("byte read", 32'(exp_read(x + X_STEP, 1'b1)), 32'(rd_cap));
    end
    run_cmd(OP_WRITE_X, 16'hfefe, 1'b0);
    run_cmd(OP_WRITE_NEXT, v, 1'b0);
    chk("debug space write", {16'hff00, 2'h1}, {cap_addr, cap_write, cap_sel});
    run_cmd(OP_READ_NEXT, 16'h0000, 1'b0);
    chk("debug space read", {16'hff02, 1'b1}, {cap_addr, cap_sel});
    chk("no ack while disabled", 0, ack_count);
    pulse_en(1'b1, 1'b1);
    chk("enable set wins", 1, 32'(ack_enable));
    for (int i = 0; i < 6; i++) begin
      a0 = ack_count;
      run_cmd(ack_ops[i], 16'($urandom), 1'b0);
      chk("ack count", a0 + 1, ack_count);
      chk("ack low clocks", 128, low_len);
      if (i == 0) chk("ack delay", 1, 32'(ack_cyc - rdv_cyc > 248));
      if (i > 3) chk("ack after return", 1, 32'(ack_cyc > ret_cyc));
    end
    vco_half <= 1'b1;
    run_cmd(OP_READ_Y, 16'h0000, 1'b0);
    chk("ack low half rate", 256, low_len);
    vco_half <= 1'b0;
    system_stop <= 1'b1;
    a0 = ack_count;
    r0 = rdv_cyc;
    issue(OP_READ_X, 16'h0000, 1'b0);
    repeat (40) @(posedge clk_sys);
    chk("stop ignores read", r0, rdv_cyc);
    system_stop <= 1'b0;
    issue(OP_READ_X, 16'h0000, 1'b0);
    repeat (40) @(posedge clk_sys);
    system_stop <= 1'b1;
    repeat (400) @(posedge clk_sys);
    chk("stop ignores ack", a0, ack_count);
    system_stop <= 1'b0;
    return_en <= 1'b0;
    repeat (30) @(posedge clk_sys);
    a0 = ack_count;
    issue(OP_RUN_UNTIL, 16'h0000, 1'b0);
    repeat (300) @(posedge clk_sys);
    cpu_wait_stop <= 1'b1;
    wait_idle();
    cpu_wait_stop <= 1'b0;
    return_en <= 1'b1;
    chk("dropped run-until", a0, ack_count);
    cpu_wait_stop <= 1'b1;
    r0 = rdv_cyc;
    run_cmd(OP_READ_NEXT, 16'h0000, 1'b0);
    cpu_wait_stop <= 1'b0;
    chk("dropped bus read ack", a0, ack_count);
    chk("dropped bus read data", r0, rdv_cyc);
    pulse_en(1'b0, 1'b1);
    run_cmd(OP_READ_X, 16'h0000, 1'b0);
    chk("cleared enable ack", a0, ack_count);
    chk("cleared enable", 0, 32'(ack_enable));
    complete_run();
  end
endmodule
`default_nettype wire
